// *** core/bld_pkg.sv ***
package bld_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int INSTR_W = 14;
	localparam int PC_W    = 13;
	localparam int ADDR_W  = 7;
	localparam int DATA_W  = 8;
	localparam int STACK_D = 8;

	// ----------------------------------------
	// Fixed opcodes and fields
	// ----------------------------------------
	localparam logic [13:0] OPC_NOP          = 14'h0000;
	localparam logic [13:0] OPC_RETURN       = 14'h0008;
	localparam logic [13:0] OPC_INT_RETURN   = 14'h0009;
	localparam logic [13:0] OPC_SLEEP        = 14'h0063;
	localparam logic [13:0] OPC_WDT_CLEAR    = 14'h0064;
	localparam logic [1:0]  GRP_BIT          = 2'h1;
	localparam logic [1:0]  BIT_CLEAR        = 2'h0;
	localparam logic [1:0]  BIT_SET          = 2'h1;
	localparam logic [1:0]  BIT_TEST_CLEAR   = 2'h2;
	localparam logic [1:0]  BIT_TEST_SET     = 2'h3;
	localparam logic [4:0]  LIT_ADD          = 5'h1F;
	localparam logic [5:0]  LIT_AND          = 6'h39;
	localparam logic [5:0]  LIT_OR           = 6'h38;
	localparam logic [5:0]  LIT_XOR          = 6'h3A;
	localparam logic [4:0]  LIT_SUB          = 5'h1E;
	localparam logic [3:0]  LIT_MOVE         = 4'hC;
	localparam logic [3:0]  LIT_RETURN       = 4'hD;
	localparam logic [2:0]  CTL_CALL         = 3'h4;
	localparam logic [2:0]  CTL_JUMP         = 3'h5;
	localparam logic [5:0]  REG_ADD          = 6'h07;

	// ----------------------------------------
	// Special file addresses
	// ----------------------------------------
	localparam logic [6:0]  IO_PORT_ADDR     = 7'h05;
	localparam logic [6:0]  TIMER_ZERO_ADDR  = 7'h01;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [12:0] PC_RESET         = 13'h0000;
	localparam logic [7:0]  ACC_RESET        = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ph_fetch, ph_address, ph_read, ph_execute
	} bld_phase_type;

	typedef enum logic [4:0] {
		op_none, op_bit_clear, op_bit_set, op_test_clear, op_test_set,
		op_add_lit, op_and_lit, op_or_lit, op_xor_lit, op_sub_lit, op_move_lit,
		op_ret_lit, op_call, op_jump, op_return, op_int_return,
		op_sleep, op_wdt_clear, op_add_reg
	} bld_op_type;

	typedef struct packed {
		logic carry;
		logic nibble_overflow;
		logic zero;
		logic timeout_flag;
		logic powerdown_flag;
	} bld_status_type;

	localparam bld_status_type STATUS_RESET = 5'h03;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic       we;
	} bld_file_type;

	typedef struct packed {
		logic [7:0] sum;
		logic       carry;
		logic       nibble_overflow;
	} bld_sum_type;

endpackage

// *** core/bld_core.sv ***
`timescale 1ns/10ps

// Functional notes
// [RULE_01] Opcode 01 00: clear selected bit of addressed register, flags unchanged.
// [RULE_02] Opcode 01 01: set selected bit of addressed register, flags unchanged.
// [RULE_03] Opcode 01 10: skip next instruction as no-op when tested bit is zero.
// [RULE_04] Opcode 01 11: skip next instruction when tested bit is one; two cycles.
// [RULE_05] Add literal to accumulator, update carry, nibble overflow and zero.
// [RULE_06] AND literal with accumulator, update only zero.
// [RULE_07] OR literal into accumulator in one cycle, update only zero.
// [RULE_08] Return from subroutine with literal in accumulator, two cycles.
// [RULE_09] Literal minus accumulator into accumulator, update carry, nibble overflow, zero.
// [RULE_10] XOR literal with accumulator in one cycle, update only zero.
// [RULE_11] Standby opcode enters standby in one cycle, updates timeout and powerdown flags.
// [RULE_12] Read-modify-write of I/O port uses sampled pin levels as operand.
// [RULE_13] Writing timer zero count clears its prescaler when assigned to it.
// [RULE_14] Program counter change or true test costs second cycle as no-op.
// [RULE_15] Add accumulator to register, destination bit picks accumulator or register.
// [RULE_16] Each instruction cycle is four clock periods.
// [RULE_17] Call pushes return address, loads 11-bit target plus upper latch bits.
// [RULE_18] Watchdog clear resets watchdog and prescaler, sets timeout and powerdown flags. Code clears prescaler only while prescaler_to_timer is low.
// [RULE_19] Jump, subroutine return and interrupt return are two-cycle pc changes.
module bld_core
	import bld_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// Program memory
	output logic [PC_W-1:0]            prog_addr,
	input  wire logic [INSTR_W-1:0]    instr_word,
	// File register bus
	output bld_file_type               file_bus,
	input  wire logic [DATA_W-1:0]     file_rdata,
	input  wire logic [4:0]            upper_pc_latch,
	// Port pins, timer and watchdog
	input  wire logic [DATA_W-1:0]     pin_level,
	input  wire logic                  prescaler_to_timer,
	output logic                       prescaler_clear,
	output logic                       watchdog_clear,
	// Core state
	input  wire logic                  wake_event,
	output logic                       standby,
	output logic                       int_enable,
	output logic [DATA_W-1:0]          accumulator,
	output bld_status_type             status
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic bld_op_type decode_op(input logic [13:0] w);
		bld_op_type op;
		op = op_none;
		if (w[13:12] == GRP_BIT) begin
			case (w[11:10])
				BIT_CLEAR:      op = op_bit_clear;
				BIT_SET:        op = op_bit_set;
				BIT_TEST_CLEAR: op = op_test_clear;
				default:        op = op_test_set;
			endcase
		end else if (w[13:9] == LIT_ADD) begin
			op = op_add_lit;
		end else if (w[13:9] == LIT_SUB) begin
			op = op_sub_lit;
		end else if (w[13:8] == LIT_AND) begin
			op = op_and_lit;
		end else if (w[13:8] == LIT_OR) begin
			op = op_or_lit;
		end else if (w[13:8] == LIT_XOR) begin
			op = op_xor_lit;
		end else if (w[13:10] == LIT_MOVE) begin
			op = op_move_lit;
		end else if (w[13:10] == LIT_RETURN) begin
			op = op_ret_lit;
		end else if (w[13:11] == CTL_CALL) begin
			op = op_call;
		end else if (w[13:11] == CTL_JUMP) begin
			op = op_jump;
		end else if (w[13:8] == REG_ADD) begin
			op = op_add_reg;
		end else if (w == OPC_RETURN) begin
			op = op_return;
		end else if (w == OPC_INT_RETURN) begin
			op = op_int_return;
		end else if (w == OPC_SLEEP) begin
			op = op_sleep;
		end else if (w == OPC_WDT_CLEAR) begin
			op = op_wdt_clear;
		end
		return op;
	endfunction

	// Shared adder for add and subtract; borrow is the inverted carry
	function automatic bld_sum_type add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		bld_sum_type r;
		logic [8:0]  full;
		logic [4:0]  low;
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.sum = full[7:0];
		r.carry = full[8];
		r.nibble_overflow = low[4];
		return r;
	endfunction

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	bld_phase_type      phase;
	logic [13:0]        instr;
	logic               flush;
	logic [DATA_W-1:0]  pin_meta;
	logic [DATA_W-1:0]  pin_sync;
	logic [PC_W-1:0]    stack_mem [STACK_D];
	logic [2:0]         stack_ptr;
	bld_op_type         op;
	logic [7:0]         literal;
	logic [2:0]         bit_sel;
	logic               dest_reg;
	logic [7:0]         operand;
	logic               tested_bit;
	logic               do_exec;
	bld_sum_type        add_res;
	logic [7:0]         next_acc;
	logic               acc_load;
	logic               logic_zero_only;
	logic               take_skip;
	logic               pc_change;
	logic               file_write;
	logic [7:0]         next_file;

	assign op         = decode_op(instr);
	assign literal    = instr[7:0];
	assign bit_sel    = instr[9:7];
	assign dest_reg   = instr[7];
	assign do_exec    = (phase == ph_execute) && !standby;
	assign tested_bit = operand[bit_sel];

	// Port reads take pin levels, never the output latch
	assign operand = (file_bus.addr == IO_PORT_ADDR) ? pin_sync : file_rdata; // [RULE_12]

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= pin_level;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------
	// Four-clock instruction cycle
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phase <= ph_fetch;
		end else begin
			case (phase) // [RULE_16]
				ph_fetch:   phase <= ph_address;
				ph_address: phase <= ph_read;
				ph_read:    phase <= ph_execute;
				ph_execute: phase <= ph_fetch;
				default:    phase <= ph_fetch;
			endcase
		end
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	always_comb begin
		add_res = add8(accumulator, literal, 1'b0);
		next_acc = accumulator;
		acc_load = 1'b0;
		logic_zero_only = 1'b0;
		file_write = 1'b0;
		next_file = operand;
		take_skip = 1'b0;
		pc_change = 1'b0;
		case (op)
			op_bit_clear: begin
				next_file[bit_sel] = 1'b0; // [RULE_01]
				file_write = 1'b1;
			end
			op_bit_set: begin
				next_file[bit_sel] = 1'b1; // [RULE_02]
				file_write = 1'b1;
			end
			op_test_clear: take_skip = !tested_bit; // [RULE_03]
			op_test_set:   take_skip = tested_bit; // [RULE_04]
			op_add_lit: begin
				next_acc = add_res.sum; // [RULE_05]
				acc_load = 1'b1;
			end
			op_sub_lit: begin
				add_res = add8(literal, ~accumulator, 1'b1); // [RULE_09]
				next_acc = add_res.sum;
				acc_load = 1'b1;
			end
			op_add_reg: begin
				add_res = add8(accumulator, operand, 1'b0); // [RULE_15]
				next_acc = dest_reg ? accumulator : add_res.sum;
				next_file = add_res.sum;
				file_write = dest_reg;
			end
			op_and_lit: begin
				next_acc = accumulator & literal; // [RULE_06]
				logic_zero_only = 1'b1;
			end
			op_or_lit: begin
				next_acc = accumulator | literal; // [RULE_07]
				logic_zero_only = 1'b1;
			end
			op_xor_lit: begin
				next_acc = accumulator ^ literal; // [RULE_10]
				logic_zero_only = 1'b1;
			end
			op_move_lit: next_acc = literal;
			op_ret_lit: begin
				next_acc = literal; // [RULE_08]
				pc_change = 1'b1;
			end
			op_call, op_jump, op_return, op_int_return: pc_change = 1'b1; // [RULE_19]
			default: begin
			end
		endcase
	end

	// ----------------------------------------
	// Accumulator and flags
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			accumulator <= ACC_RESET;
			status <= STATUS_RESET;
		end else if (do_exec) begin
			accumulator <= next_acc;
			if (acc_load || op == op_add_reg) begin
				status.carry <= add_res.carry; // [RULE_05] [RULE_09] [RULE_15]
				status.nibble_overflow <= add_res.nibble_overflow;
				status.zero <= (add_res.sum == 8'h00);
			end else if (logic_zero_only) begin
				status.zero <= (next_acc == 8'h00); // [RULE_06] [RULE_07] [RULE_10]
			end
			if (op == op_sleep) begin
				status.timeout_flag <= 1'b1; // [RULE_11]
				status.powerdown_flag <= 1'b0;
			end else if (op == op_wdt_clear) begin
				status.timeout_flag <= 1'b1; // [RULE_18]
				status.powerdown_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Fetch, program counter and stack
	// ----------------------------------------
	// Stack wraps silently on overflow, as a fixed-depth ring
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prog_addr <= PC_RESET;
			instr <= OPC_NOP;
			flush <= 1'b0;
			stack_ptr <= 3'h0;
			int_enable <= 1'b0;
		end else if (phase == ph_fetch && !standby) begin
			flush <= 1'b0;
			if (flush) begin
				instr <= OPC_NOP; // [RULE_14]
			end else begin
				instr <= instr_word;
				prog_addr <= prog_addr + 13'h0001;
			end
		end else if (do_exec) begin
			flush <= take_skip || pc_change; // [RULE_14]
			if (take_skip) begin
				prog_addr <= prog_addr + 13'h0001; // [RULE_03] [RULE_04]
			end
			case (op)
				op_call: begin
					stack_mem[stack_ptr] <= prog_addr; // [RULE_17]
					stack_ptr <= stack_ptr + 3'h1;
					prog_addr <= {upper_pc_latch[4:3], instr[10:0]};
				end
				op_jump: prog_addr <= {upper_pc_latch[4:3], instr[10:0]}; // [RULE_19]
				op_return, op_ret_lit, op_int_return: begin
					prog_addr <= stack_mem[stack_ptr - 3'h1]; // [RULE_08] [RULE_19]
					stack_ptr <= stack_ptr - 3'h1;
					if (op == op_int_return) begin
						int_enable <= 1'b1;
					end
				end
				op_sleep: instr <= OPC_NOP; // [RULE_11]
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// File register bus
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			file_bus <= '0;
		end else begin
			if (phase == ph_address) begin
				file_bus.addr <= instr[6:0];
			end
			file_bus.we <= do_exec && file_write; // [RULE_01] [RULE_02] [RULE_15]
			if (do_exec) begin
				file_bus.wdata <= next_file;
			end
		end
	end

	// ----------------------------------------
	// Timer, watchdog and standby
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prescaler_clear <= 1'b0;
			watchdog_clear <= 1'b0;
			standby <= 1'b0;
		end else begin
			prescaler_clear <= (do_exec && file_write && file_bus.addr == TIMER_ZERO_ADDR
				&& prescaler_to_timer) || (do_exec && op == op_wdt_clear && !prescaler_to_timer); // [RULE_13] [RULE_18]
			watchdog_clear <= do_exec && op == op_wdt_clear; // [RULE_18]
			if (do_exec && op == op_sleep) begin
				standby <= 1'b1; // [RULE_11]
			end else if (wake_event) begin
				standby <= 1'b0;
			end
		end
	end
endmodule

// *** verification/bld_core_sva.sv ***
`timescale 1ns/10ps
// --------
// Port checker
// --------
module bld_core_sva
	import bld_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              resetn,
	// Observed ports
	input wire logic [PC_W-1:0]   prog_addr,
	input wire bld_file_type      file_bus,
	input wire logic              prescaler_to_timer,
	input wire logic              prescaler_clear,
	input wire logic              watchdog_clear,
	input wire logic              standby,
	input wire logic              int_enable,
	input wire logic [DATA_W-1:0] accumulator,
	input wire bld_status_type    status
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Fetch and execute edges of one cycle lie at least three clocks apart
	sequence s_pc_settle;
		$stable(prog_addr)[*2];
	endsequence
	sequence s_acc_settle;
		$stable(accumulator)[*3];
	endsequence
	sequence s_asleep;
		standby ##1 standby;
	endsequence

	a_write_one_pulse: assert property (file_bus.we |=> !file_bus.we)
		else $error("write strobe too long");
	a_pc_step_spacing: assert property ($changed(prog_addr) |=> s_pc_settle)
		else $error("program address changed too soon");
	a_acc_cycle_spacing: assert property ($changed(accumulator) |=> s_acc_settle)
		else $error("accumulator changed twice in one cycle");
	a_sleep_sets_flags: assert property ($rose(standby) |-> status.timeout_flag && !status.powerdown_flag)
		else $error("standby flags wrong");
	a_standby_no_fetch: assert property (s_asleep |-> $stable(prog_addr))
		else $error("fetch during standby");
	a_wdog_sets_flags: assert property (watchdog_clear |-> status.timeout_flag && status.powerdown_flag)
		else $error("watchdog clear flags wrong");
	a_wdog_prescaler_clear: assert property (watchdog_clear && !prescaler_to_timer |-> prescaler_clear)
		else $error("watchdog prescaler not cleared");
	a_timer_prescaler_clear: assert property (
		file_bus.we && file_bus.addr == TIMER_ZERO_ADDR && prescaler_to_timer |-> prescaler_clear)
		else $error("timer prescaler not cleared");
	a_prescaler_one_pulse: assert property (prescaler_clear |=> !prescaler_clear)
		else $error("prescaler clear too long");
	a_int_enable_sticky: assert property (int_enable |=> int_enable)
		else $error("interrupt enable dropped");
endmodule

bind bld_core bld_core_sva bld_core_sva_inst (
	.sys_clk(sys_clk), .resetn(resetn), .prog_addr(prog_addr), .file_bus(file_bus),
	.prescaler_to_timer(prescaler_to_timer), .prescaler_clear(prescaler_clear),
	.watchdog_clear(watchdog_clear), .standby(standby), .int_enable(int_enable),
	.accumulator(accumulator), .status(status)
);

// *** verification/bld_prog_mem.sv ***
`timescale 1ns/10ps
module bld_prog_mem
	import bld_pkg::*;
(
	// Fetch side
	input wire logic [PC_W-1:0] prog_addr,
	output logic [INSTR_W-1:0]  instr_word
);
	logic [INSTR_W-1:0] mem [2**PC_W];

	// Plain asynchronous read, the core samples at its fetch edge
	assign instr_word = mem[prog_addr];

	initial begin
		for (int i = 0; i < 2**PC_W; i++) begin
			mem[i] = OPC_NOP;
		end
	end
endmodule

// *** verification/bld_core_tb_top.sv ***
`timescale 1ns/10ps
module bld_core_tb_top
	import bld_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn, prescaler_to_timer, prescaler_clear, watchdog_clear, wake_event, standby, int_enable;
	logic [PC_W-1:0] prog_addr;
	logic [INSTR_W-1:0] instr_word;
	logic [4:0] upper_pc_latch;
	logic [DATA_W-1:0] file_rdata, pin_level, accumulator, ram [128], snap_acc [32];
	bld_file_type file_bus;
	bld_status_type status, st_sleep, snap_st [32];
	logic [14:0] wq [$];
	int bad_count, n_checks, pc_cnt, wd_cnt, fe;

	always #2.5 sys_clk = ~sys_clk;
	assign file_rdata = ram[file_bus.addr];

	// File register model, logs every write
	always @(posedge sys_clk) begin
		if (resetn && file_bus.we) begin
			ram[file_bus.addr] <= file_bus.wdata;
			wq.push_back({file_bus.addr, file_bus.wdata});
		end
		if (resetn && prescaler_clear) pc_cnt++;
		if (resetn && watchdog_clear) wd_cnt++;
	end

	bld_core bld_core_inst (.sys_clk(sys_clk), .resetn(resetn), .prog_addr(prog_addr), .instr_word(instr_word),
		.file_bus(file_bus), .file_rdata(file_rdata), .upper_pc_latch(upper_pc_latch), .pin_level(pin_level),
		.prescaler_to_timer(prescaler_to_timer), .prescaler_clear(prescaler_clear),
		.watchdog_clear(watchdog_clear), .wake_event(wake_event), .standby(standby),
		.int_enable(int_enable), .accumulator(accumulator), .status(status));
	bld_prog_mem bld_prog_mem_inst (.prog_addr(prog_addr), .instr_word(instr_word));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic ld(input logic [12:0] a, input logic [13:0] w);
		bld_prog_mem_inst.mem[a] = w;
	endtask

	function automatic logic [13:0] bop(input logic [1:0] op, input logic [2:0] b, input logic [6:0] f);
		return {GRP_BIT, op, b, f};
	endfunction

	// Reset, run from 0 until the word at stop is fetched; snapshot after each of the first 31 execute edges
	task automatic run_prog(input logic [12:0] stop, input logic ptt);
		int sb;
		sb = 0;
		fe = -1;
		@(negedge sys_clk);
		resetn = 1'b0;
		prescaler_to_timer = ptt;
		st_sleep = 5'h1F;
		wq.delete();
		pc_cnt = 0;
		wd_cnt = 0;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		for (int k = 1; k < 600 && (fe < 0 || k <= fe + 4); k++) begin
			@(negedge sys_clk);
			if (k % 4 == 0 && k < 128) begin
				snap_acc[k/4-1] = accumulator;
				snap_st[k/4-1] = status;
			end
			if (standby === 1'b1) begin
				if (sb == 0) st_sleep = status;
				sb++;
			end
			wake_event = standby === 1'b1 && sb >= 6;
			if (fe < 0 && prog_addr === stop + 13'h1) fe = k;
		end
		if (fe < 0) begin
			bad_count++;
			$display("[ERR] run stalled before %h", stop);
			summarize();
		end
	endtask

	task automatic t_literal();
		logic [7:0] ea [9] = '{8'h8F, 8'h00, 8'h5A, 8'h00, 8'h3C, 8'h0C, 8'hFE, 8'h00, 8'h05};
		logic [4:0] es [9] = '{5'h03, 5'h1F, 5'h1B, 5'h1F, 5'h1F, 5'h1B, 5'h03, 5'h1F, 5'h1B};
		ld(0, {LIT_MOVE, 2'h0, 8'h8F});
		ld(1, {LIT_ADD, 1'h0, 8'h71});
		ld(2, {LIT_OR, 8'h5A});
		ld(3, {LIT_XOR, 8'h5A});
		ld(4, {LIT_MOVE, 2'h0, 8'h3C});
		ld(5, {LIT_AND, 8'h0F});
		ld(6, {LIT_SUB, 1'h0, 8'h0A});
		ld(7, {LIT_ADD, 1'h1, 8'h02});
		ld(8, {LIT_SUB, 1'h1, 8'h05});
		ld(9, {CTL_JUMP, 11'h009});
		run_prog(13'h0009, 1'b0);
		for (int c = 0; c < 9; c++) begin
			check("literal acc", {8'h00, snap_acc[c]}, {8'h00, ea[c]});
			check("literal flags", {11'h000, snap_st[c]}, {11'h000, es[c]});
		end
		check("literal cycles", 16'(fe), 16'h0025);
		$display("literal test done");
	endtask

	task automatic t_bits();
		logic [14:0] ew [4] = '{{7'h10, 8'h8F}, {7'h10, 8'h8E}, {IO_PORT_ADDR, 8'hA1}, {7'h10, 8'hD2}};
		ram[16] = 8'h0F;
		ram[5] = 8'h5E;
		ld(0, bop(BIT_SET, 3'h7, 7'h10));
		ld(1, bop(BIT_CLEAR, 3'h0, 7'h10));
		ld(2, bop(BIT_TEST_CLEAR, 3'h0, 7'h10));
		ld(3, {LIT_MOVE, 2'h0, 8'h11});
		ld(4, bop(BIT_TEST_SET, 3'h0, 7'h10));
		ld(5, {LIT_MOVE, 2'h0, 8'h22});
		ld(6, bop(BIT_TEST_SET, 3'h7, 7'h10));
		ld(7, {LIT_MOVE, 2'h0, 8'h33});
		ld(8, bop(BIT_TEST_CLEAR, 3'h7, 7'h10));
		ld(9, {LIT_MOVE, 2'h0, 8'h44});
		ld(10, bop(BIT_SET, 3'h0, IO_PORT_ADDR));
		ld(11, {REG_ADD, 1'h1, 7'h10});
		ld(12, {REG_ADD, 1'h0, 7'h10});
		ld(13, {CTL_JUMP, 11'h00D});
		run_prog(13'h000D, 1'b1);
		check("skip cycles", 16'(fe), 16'h0035);
		check("acc after clear skip", {8'h00, snap_acc[3]}, 16'h0000);
		check("acc after set skip", {8'h00, snap_acc[7]}, 16'h0022);
		check("bit op flags", {11'h000, snap_st[10]}, 16'h0003);
		check("reg add flags", {11'h000, snap_st[11]}, 16'h000B);
		check("reg add acc", {8'h00, snap_acc[12]}, 16'h0016);
		check("reg add acc flags", {11'h000, snap_st[12]}, 16'h0013);
		check("write count", 16'(wq.size()), 16'h0004);
		for (int i = 0; i < 4 && i < wq.size(); i++) begin
			check("file write", {1'b0, wq[i]}, {1'b0, ew[i]});
		end
		$display("bit test done");
	endtask

	task automatic t_flow();
		// Low latch bits set too, only bits 4:3 may reach the pc
		upper_pc_latch = 5'h0B;
		ld(0, {CTL_CALL, 11'h020});
		ld(13'h0820, {LIT_RETURN, 2'h0, 8'h5A});
		ld(1, {CTL_CALL, 11'h030});
		ld(13'h0830, OPC_RETURN);
		ld(2, {CTL_CALL, 11'h040});
		ld(13'h0840, OPC_INT_RETURN);
		ld(3, {CTL_JUMP, 11'h050});
		ld(13'h0850, {CTL_JUMP, 11'h050});
		run_prog(13'h0850, 1'b0);
		check("flow cycles", 16'(fe), 16'h0039);
		check("return literal acc", {8'h00, snap_acc[3]}, 16'h005A);
		check("interrupt enable", {15'h0000, int_enable}, 16'h0001);
		$display("flow test done");
	endtask

	task automatic t_standby(input logic ptt);
		ld(0, OPC_SLEEP);
		ld(1, OPC_WDT_CLEAR);
		ld(2, bop(BIT_SET, 3'h0, TIMER_ZERO_ADDR));
		ld(3, bop(BIT_CLEAR, 3'h1, TIMER_ZERO_ADDR));
		ld(4, {CTL_JUMP, 11'h004});
		run_prog(13'h0004, ptt);
		check("sleep flags", {11'h000, st_sleep}, 16'h0002);
		check("wdog flags", {11'h000, status}, 16'h0003);
		check("wdog pulses", 16'(wd_cnt), 16'h0001);
		check("prescaler pulses", 16'(pc_cnt), ptt ? 16'h0002 : 16'h0001);
		$display("standby test done");
	endtask

	initial begin
		resetn = 1'b0;
		wake_event = 1'b0;
		pin_level = 8'hA0;
		prescaler_to_timer = 1'b0;
		upper_pc_latch = 5'h00;
		bad_count = 0;
		n_checks = 0;
		pc_cnt = 0;
		wd_cnt = 0;
		for (int i = 0; i < 128; i++) ram[i] = 8'h00;
		@(negedge sys_clk);
		t_literal();
		t_bits();
		t_flow();
		t_standby(1'b0);
		t_standby(1'b1);
		summarize();
	end
endmodule
